// >>> verilog/bcwl_pkg.sv
/*
 holds the constants of the control-word low-bit decoder: field positions,
 message types, register offsets and reset values.
 assumes an ahb-lite slave with 32-bit word registers.
*/
`default_nettype none
package bcwl_pkg;
   // control word field positions
   localparam int BCWL_BCR_CHECK_POS = 5;
   localparam int BCWL_SELIRQ_POS    = 4;
   localparam int BCWL_LEGACY_POS    = 3;
   localparam int BCWL_MCODE_POS     = 2;
   localparam int BCWL_BCAST_POS     = 1;
   localparam int BCWL_RTRT_POS      = 0;
   // status word broadcast-received bit
   localparam int BCWL_STS_BCR_POS   = 4;
   // interrupt enable / pending bit for the selected message
   localparam int BCWL_SELECTED_MESSAGE_IRQ_POS    = 14;
   // configuration bits
   localparam int BCWL_BME_POS       = 0;
   localparam int BCWL_LEGMODE_POS   = 5;
   // register byte offsets
   localparam logic [7:0] BCWL_CFG_OFS    = 8'h00;
   localparam logic [7:0] BCWL_CTRL_OFS   = 8'h04;
   localparam logic [7:0] BCWL_IEN_OFS    = 8'h08;
   localparam logic [7:0] BCWL_PEND_OFS   = 8'h0c;
   localparam logic [7:0] BCWL_STATUS_OFS = 8'h10;
   localparam logic [7:0] BCWL_ISTAT_OFS  = 8'h14;
   localparam logic [7:0] BCWL_IMASK_OFS  = 8'h18;
   localparam logic [31:0] BCWL_RESET_VAL = 32'h0000_0000;
   // sticky event bits
   localparam int BCWL_EV_DONE_POS   = 0;
   localparam int BCWL_EV_SSET_POS   = 1;
   localparam int BCWL_EV_SELIRQ_POS = 2;
   localparam int BCWL_EV_BADFMT_POS = 3;
   localparam int BCWL_EV_W          = 4;

   typedef enum logic [2:0]
   {
      BCWL_BC_TO_RT,
      BCWL_RT_TO_BC,
      BCWL_RT_TO_RT,
      BCWL_BC_BC_TO_RT,
      BCWL_BC_RT_TO_RT,
      BCWL_MODE_CODE,
      BCWL_BC_MODE_CODE,
      BCWL_ILLEGAL
   } bcwl_msg_type;
endpackage
`default_nettype wire

// >>> verilog/bcwl_control_word_low_bits.sv
/*
 control-word low-bit decoder of the bus-controller engine, with an
 ahb-lite register slave and a sticky-status interrupt.
 assumes a single ahb-lite master, word transfers only, and that the
 message engine pulses msg_start and msg_done in that order.
*/
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bcwl_control_word_low_bits
   import bcwl_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        msg_start,
   input  wire logic        msg_done,
   input  wire logic        cmd_tr_bit,
   input  wire logic [4:0]  cmd_subaddr,
   input  wire logic        rt_status_valid,
   input  wire logic [15:0] rt_status_word,
   output logic      [2:0]  msg_type,
   output logic             mode_code_msg,
   output logic             expect_mode_data,
   output logic             legacy_response_expected,
   output logic             status_set,
   output logic             irq
);
   logic [5:0]  ctrl_q;
   logic [5:0]  lat_q;
   logic [15:0] cfg_q;
   logic [15:0] ien_q;
   logic [15:0] pend_q;
   logic        active_q;
   logic        sset_q;
   logic [BCWL_EV_W-1:0] istat_q;
   logic [BCWL_EV_W-1:0] imask_q;
   logic        wr_q;
   logic        rd_q;
   logic [7:0]  addr_q;
   logic [31:0] rdata_q;
   logic [2:0]  type_q;
   logic        mcode_q;
   logic        mdata_q;
   logic        sset_d;
   logic        bad_fmt;
   logic        sel_irq_ev;
   logic [BCWL_EV_W-1:0] ev;

   function automatic logic [2:0] bcwl_decode
   (
      input logic [2:0] fmt,
      input logic       tr
   );
      bcwl_msg_type t;
      t = BCWL_ILLEGAL;
      unique case (fmt)
         3'h0: t = tr ? BCWL_RT_TO_BC : BCWL_BC_TO_RT;
         3'h1: t = BCWL_RT_TO_RT;
         3'h2: t = BCWL_BC_BC_TO_RT;
         3'h3: t = BCWL_BC_RT_TO_RT;
         3'h4: t = BCWL_MODE_CODE;
         3'h6: t = BCWL_BC_MODE_CODE;
         3'h5, 3'h7: t = BCWL_ILLEGAL;
      endcase
      return t;
   endfunction

   wire addr_ph = hsel && hready && htrans[1];

   // bus address phase capture; zero wait states, the slave never stretches
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 8'h00;
      end
      else
      begin
         wr_q   <= addr_ph && hwrite;
         rd_q   <= addr_ph && !hwrite;
         if (addr_ph)
            addr_q <= haddr[7:0];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // software registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_q   <= BCWL_RESET_VAL[15:0];
         ctrl_q  <= BCWL_RESET_VAL[5:0];
         ien_q   <= BCWL_RESET_VAL[15:0];
         imask_q <= BCWL_RESET_VAL[BCWL_EV_W-1:0];
      end
      else if (wr_q)
      begin
         unique case (addr_q)
            BCWL_CFG_OFS:   cfg_q   <= hwdata[15:0];
            BCWL_CTRL_OFS:  ctrl_q  <= hwdata[5:0];
            BCWL_IEN_OFS:   ien_q   <= hwdata[15:0];
            BCWL_IMASK_OFS: imask_q <= hwdata[BCWL_EV_W-1:0];
            default:        ;
         endcase
      end
   end

   // latch at start
   // a start while busy is ignored so the latched bits cannot move mid message
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lat_q    <= 6'h00;
         active_q <= 1'b0;
      end
      else if (msg_start && !active_q)
      begin
         lat_q    <= ctrl_q;
         active_q <= 1'b1;
      end
      else if (msg_done)
         active_q <= 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         type_q  <= 3'h0;
         mcode_q <= 1'b0;
         mdata_q <= 1'b0;
      end
      else
      begin
         type_q  <= bcwl_decode(lat_q[BCWL_MCODE_POS:BCWL_RTRT_POS],
                                cmd_tr_bit);
         if (lat_q[BCWL_LEGACY_POS])
            mcode_q <= lat_q[BCWL_MCODE_POS] && (cmd_subaddr == 5'h00);
         else
            // 1553b also takes subaddress 31 as a mode code
            mcode_q <= lat_q[BCWL_MCODE_POS]
                       && ((cmd_subaddr == 5'h00) || (cmd_subaddr == 5'h1f));
         mdata_q <= lat_q[BCWL_MCODE_POS] && !lat_q[BCWL_LEGACY_POS]
                    && cmd_subaddr != 5'h00;
      end
   end

   assign msg_type         = type_q;
   assign mode_code_msg    = mcode_q;
   assign expect_mode_data = mdata_q;
   assign legacy_response_expected = lat_q[BCWL_LEGACY_POS];
   assign bad_fmt = (bcwl_decode(lat_q[BCWL_MCODE_POS:BCWL_RTRT_POS],
                                 1'b0) == BCWL_ILLEGAL);

   // status-set from broadcast-received bit
   always_comb
   begin
      sset_d = 1'b0;
      if (cfg_q[BCWL_BME_POS])
         sset_d = !lat_q[BCWL_BCR_CHECK_POS]
                  && rt_status_word[BCWL_STS_BCR_POS];
      else
         sset_d = lat_q[BCWL_BCR_CHECK_POS]
                  != rt_status_word[BCWL_STS_BCR_POS];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         sset_q <= 1'b0;
      else if (msg_start && !active_q)
         sset_q <= 1'b0;
      else if (rt_status_valid && active_q)
         sset_q <= sset_d;
   end
   assign status_set = sset_q;

   assign sel_irq_ev = msg_done && active_q && lat_q[BCWL_SELIRQ_POS]
                       && ien_q[BCWL_SELECTED_MESSAGE_IRQ_POS];

   wire rd_pend  = rd_q && (addr_q == BCWL_PEND_OFS);
   wire rd_istat = rd_q && (addr_q == BCWL_ISTAT_OFS);

   // set wins over read-clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pend_q <= 16'h0000;
      else
      begin
         if (rd_pend)
            pend_q <= 16'h0000;
         if (sel_irq_ev)
            pend_q[BCWL_SELECTED_MESSAGE_IRQ_POS] <= 1'b1;
      end
   end

   always_comb
   begin
      ev = '0;
      ev[BCWL_EV_DONE_POS]   = msg_done && active_q;
      ev[BCWL_EV_SSET_POS]   = msg_done && active_q && sset_q;
      ev[BCWL_EV_SELIRQ_POS] = sel_irq_ev;
      ev[BCWL_EV_BADFMT_POS] = msg_start && !active_q
         && (bcwl_decode(ctrl_q[BCWL_MCODE_POS:BCWL_RTRT_POS], 1'b0)
             == BCWL_ILLEGAL);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         istat_q <= '0;
      else
         istat_q <= (rd_istat ? '0 : istat_q) | ev;
   end
   assign irq = |(istat_q & imask_q);

   // read data mux
   always_comb
   begin
      rdata_q = 32'h0000_0000;
      unique case (addr_q)
         BCWL_CFG_OFS:    rdata_q[15:0] = cfg_q;
         BCWL_CTRL_OFS:   rdata_q[5:0]  = ctrl_q;
         BCWL_IEN_OFS:    rdata_q[15:0] = ien_q;
         BCWL_PEND_OFS:   rdata_q[15:0] = pend_q;
         BCWL_STATUS_OFS: rdata_q[9:0]  = {bad_fmt, active_q, sset_q,
                                           mcode_q, type_q, lat_q[5:3]};
         BCWL_ISTAT_OFS:  rdata_q[BCWL_EV_W-1:0] = istat_q;
         BCWL_IMASK_OFS:  rdata_q[BCWL_EV_W-1:0] = imask_q;
         default:         rdata_q = 32'h0000_0000;
      endcase
   end
   assign hrdata = rd_q ? rdata_q : 32'h0000_0000;

   chk_selirq_pend: assert property (@(posedge hclk) disable iff (!hresetn)
      sel_irq_ev |=> pend_q[BCWL_SELECTED_MESSAGE_IRQ_POS])
      else $error("selected message pending not set");
   chk_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      active_q && !msg_done |=> $stable(lat_q))
      else $error("control bits changed mid message");
   chk_mask_mode: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_q[0] && lat_q[5] && rt_status_valid && active_q |=> !sset_q)
      else $error("masked broadcast bit raised status set");
   chk_expect_miss: assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg_q[0] && rt_status_valid && active_q
      && (lat_q[5] != rt_status_word[4]) |=> sset_q)
      else $error("mismatch did not raise status set");
   chk_expect_match: assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg_q[0] && rt_status_valid && active_q
      && (lat_q[5] == rt_status_word[4]) |=> !sset_q)
      else $error("match raised status set");
   chk_expect_val: assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg_q[0] && !lat_q[5] && rt_status_valid && active_q
      && rt_status_word[4] |=> sset_q)
      else $error("expected value not applied");
   chk_legacy_data: assert property (@(posedge hclk) disable iff (!hresetn)
      lat_q[3] |=> !expect_mode_data)
      else $error("legacy mode code expects data");
   chk_legacy_sa: assert property (@(posedge hclk) disable iff (!hresetn)
      lat_q[3] && lat_q[2] && cmd_subaddr == 5'h1f |=> !mode_code_msg)
      else $error("legacy subaddress 31 taken as mode code");
   chk_b_default: assert property (@(posedge hclk) disable iff (!hresetn)
      msg_start && !active_q && !ctrl_q[BCWL_LEGACY_POS]
      |=> !legacy_response_expected)
      else $error("1553b response not selected");
   chk_tr_dir: assert property (@(posedge hclk) disable iff (!hresetn)
      lat_q[2:0] == 3'h0 && $stable(lat_q) |=>
      msg_type == (($past(cmd_tr_bit)) ? 3'(BCWL_RT_TO_BC)
                                      : 3'(BCWL_BC_TO_RT)))
      else $error("direction not from t/r bit");
   chk_bad_code: assert property (@(posedge hclk) disable iff (!hresetn)
      lat_q[2:0] == 3'h5 && $stable(lat_q)
      |=> msg_type == 3'(BCWL_ILLEGAL))
      else $error("do-not-use code not flagged");
   chk_b_sa31: assert property (@(posedge hclk) disable iff (!hresetn)
      !lat_q[3] && lat_q[2] && cmd_subaddr == 5'h1f
      |=> mode_code_msg)
      else $error("1553b subaddress 31 not taken as mode code");
   chk_start_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      msg_start && !active_q |=> !sset_q && active_q)
      else $error("new message kept old status set");
   chk_latch_take: assert property (@(posedge hclk) disable iff (!hresetn)
      msg_start && !active_q |=> lat_q == $past(ctrl_q))
      else $error("control bits not latched at start");
   chk_selirq_ev: assert property (@(posedge hclk) disable iff (!hresetn)
      sel_irq_ev |=> istat_q[BCWL_EV_SELIRQ_POS])
      else $error("selected message event lost");
   chk_pend_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_pend && !sel_irq_ev |=> pend_q == 16'h0000)
      else $error("pending read did not clear");
   chk_no_selirq: assert property (@(posedge hclk) disable iff (!hresetn)
      msg_done && active_q && !pend_q[BCWL_SELECTED_MESSAGE_IRQ_POS]
      && !(lat_q[BCWL_SELIRQ_POS] && ien_q[BCWL_SELECTED_MESSAGE_IRQ_POS])
      |=> !pend_q[BCWL_SELECTED_MESSAGE_IRQ_POS])
      else $error("pending bit set without request");

   cov_selirq: cover property (@(posedge hclk) disable iff (!hresetn)
      sel_irq_ev);
   cov_sset: cover property (@(posedge hclk) disable iff (!hresetn)
      msg_done && sset_q);
   cov_legacy: cover property (@(posedge hclk) disable iff (!hresetn)
      active_q && lat_q[3] && lat_q[2]);
   cov_mismatch: cover property (@(posedge hclk) disable iff (!hresetn)
      rt_status_valid && active_q && sset_d && !cfg_q[BCWL_BME_POS]);
   cov_bad_fmt: cover property (@(posedge hclk) disable iff (!hresetn)
      ev[BCWL_EV_BADFMT_POS]);
endmodule
`default_nettype wire

// >>> verification/bcwl_rt_model.sv
/*
 remote terminal model: returns a status word after a chosen wait.
 assumes the bench asks for one response at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module bcwl_rt_model
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        rsp_req,
   input  wire logic        rsp_bcr,
   input  wire logic [3:0]  rsp_wait,
   output logic             rt_status_valid,
   output logic      [15:0] rt_status_word
);
   logic [4:0] cnt_q;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_q           <= 5'h00;
         rt_status_valid <= 1'b0;
         rt_status_word  <= 16'h0000;
      end
      else
      begin
         // word wanders outside valid so stale bits are never trusted
         rt_status_valid <= cnt_q == 5'h01;
         rt_status_word  <= ~rt_status_word;
         if (rsp_req)
            cnt_q <= {1'b0, rsp_wait} + 5'h01;
         else if (cnt_q != 5'h00)
            cnt_q <= cnt_q - 5'h01;
         if (cnt_q == 5'h01)
            rt_status_word <= (16'($urandom) & 16'hffef) | {rsp_bcr, 4'h0};
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
/*
 self-checking bench of the control-word low-bit decoder.
 assumes a zero-wait slave and the rt model on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bcwl_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize, msg_type;
   logic        msg_start, msg_done, cmd_tr_bit, rt_status_valid;
   logic        status_set, irq, mode_code_msg, expect_mode_data;
   logic        legacy_response_expected, rsp_req, rsp_bcr, rd_ph;
   logic [4:0]  cmd_subaddr;
   logic [15:0] rt_status_word;
   logic [3:0]  rsp_wait;
   logic [31:0] exp_q[$], msk_q[$];
   int          fail_count, n_checks, cycles;
   assign hready = hreadyout;
   bcwl_control_word_low_bits i_dut
   (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .msg_start, .msg_done,
      .cmd_tr_bit, .cmd_subaddr, .rt_status_valid, .rt_status_word,
      .msg_type, .mode_code_msg, .expect_mode_data,
      .legacy_response_expected, .status_set, .irq
   );
   bcwl_rt_model i_rt
   (
      .hclk, .hresetn, .rsp_req, .rsp_bcr, .rsp_wait, .rt_status_valid,
      .rt_status_word
   );
   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] ex);
      n_checks++;
      if (seen !== ex)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, ex, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         summarize();
      end
   end
   // read data is judged only at the edge that ends its data phase
   always @(posedge hclk)
      if (rd_ph && hreadyout)
         check("hrdata", hrdata & msk_q.pop_front(),
               exp_q.pop_front());
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d, ex, mk);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph  <= !w;
      exp_q.push_back(ex & mk);
      msk_q.push_back(w ? 32'h0 : mk);
      if (w)
         void'(exp_q.pop_back());
      if (w)
         void'(msk_q.pop_back());
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_ph  <= 1'b0;
   endtask
   task automatic strobe(int k);
      case (k)
         0: msg_start <= 1'b1;
         1: msg_done  <= 1'b1;
         default: rsp_req <= 1'b1;
      endcase
      @(posedge hclk);
      case (k)
         0: msg_start <= 1'b0;
         1: msg_done  <= 1'b0;
         default: rsp_req <= 1'b0;
      endcase
   endtask
   function automatic logic [2:0] ty_of(logic [2:0] f, logic tr);
      case (f)
         3'h0: return tr ? BCWL_RT_TO_BC : BCWL_BC_TO_RT;
         3'h1: return BCWL_RT_TO_RT;
         3'h2: return BCWL_BC_BC_TO_RT;
         3'h3: return BCWL_BC_RT_TO_RT;
         3'h4: return BCWL_MODE_CODE;
         3'h6: return BCWL_BC_MODE_CODE;
         default: return BCWL_ILLEGAL;
      endcase
   endfunction
   task automatic run_msg(int i);
      logic [5:0]  c;
      logic        s4, ien, ss, sel, mc, bad, tr;
      logic [4:0]  sa;
      logic [3:0]  ev, mk;
      c = {6'($urandom)} & 6'h38 | 6'(i & 7);
      s4 = 1'($urandom);
      ien = 1'($urandom);
      tr = 1'($urandom);
      mk = 4'($urandom);
      sa = i[5] ? 5'($urandom) : {5{i[4]}};
      bad = c[2:0] == 3'h5 || c[2:0] == 3'h7;
      mc = c[2] && (sa == 0 || (!c[3] && sa == 31));
      ss = i[3] ? !c[5] && s4 : c[5] != s4;
      sel = c[4] & ien;
      ev = {bad, sel, ss, 1'b1};
      bus(1, BCWL_CFG_OFS, {26'h0, c[3], 4'h0, i[3]}, 0, 0);
      bus(1, BCWL_CTRL_OFS, {26'h0, c}, 0, 0);
      bus(1, BCWL_IEN_OFS, {17'h0, ien, 14'h0}, 0, 0);
      bus(1, BCWL_IMASK_OFS, {28'h0, mk}, 0, 0);
      bus(0, BCWL_ISTAT_OFS, 0, 0, 0);
      cmd_tr_bit  <= tr;
      cmd_subaddr <= sa;
      rsp_bcr     <= s4;
      rsp_wait    <= 4'($urandom);
      strobe(0);
      strobe(2);
      repeat (40)
      begin
         @(posedge hclk);
         if (rt_status_valid)
            break;
      end
      @(negedge hclk);
      check("status_set", status_set, ss);
      check("msg_type", msg_type, ty_of(c[2:0], tr));
      check("legacy", legacy_response_expected, c[3]);
      check("mode_data", expect_mode_data & c[3], 0);
      check("mode_code", mode_code_msg, mc);
      bus(1, BCWL_CTRL_OFS, {26'h0, ~c}, 0, 0);
      bus(0, BCWL_STATUS_OFS, 0, {bad, 1'b1, ss, mc,
          ty_of(c[2:0], tr), c[5:3]}, 32'h3ff);
      strobe(1);
      @(negedge hclk);
      check("irq", irq, |(ev & mk));
      bus(0, BCWL_PEND_OFS, 0, {17'h0, sel, 14'h0}, '1);
      bus(0, BCWL_ISTAT_OFS, 0, {28'h0, ev}, '1);
      $display("test %0d done", i);
   endtask
   initial
   begin
      {hsel, hwrite, msg_start, msg_done, cmd_tr_bit, rd_ph} = '0;
      {rsp_req, rsp_bcr, rsp_wait, cmd_subaddr, htrans, cycles} = '0;
      {haddr, hwdata, hresetn, fail_count, n_checks} = '0;
      hsize = 3'h2;
      void'($urandom(14520));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      for (int k = 0; k < 7; k++)
         bus(0, 8'(4 * k), 0, BCWL_RESET_VAL, '1);
      check("irq", irq, 0);
      bus(1, 8'h1c, 32'hffff_ffff, 0, 0);
      bus(0, 8'h1c, 0, 0, '1);
      $display("test reset done");
      for (int i = 0; i < 64; i++)
         run_msg(i);
      summarize();
   end
endmodule
`default_nettype wire
